// ==== core/ldks_mem.sv ====
// key and parameter storage array with registered read data
`timescale 1ns/10ps
module ldks_mem
    import ldks_pkg::*;
#(
    parameter int DEPTH  = SLOTS,
    parameter int AW     = SLOT_W,
    parameter int DATA_W = KEY_W + PARAM_W + ID_W
) (
    input  wire logic              clk_sys_in,
    input  wire logic              wr_en_in,
    input  wire logic [AW-1:0]     wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [AW-1:0]     rd_addr_in,
    output logic      [DATA_W-1:0] rd_data_out
);
    logic [DATA_W-1:0] store [DEPTH];

    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("ldks_mem depth exceeds address range");
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            store[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        rd_data_out <= store[rd_addr_in];
    end
endmodule

// ==== core/ldks_pkg.sv ====
// shared constants and types of the link decryptor key store
package ldks_pkg;
    localparam int KEY_W         = 128;
    localparam int PARAM_W       = 32;
    localparam int ID_W          = 32;
    localparam int REQ_W         = 8;
    localparam int TIME_W        = 32;
    localparam int SLOTS         = 16;
    localparam int SLOT_W        = 4;
    localparam int CNT_W         = 5;
    localparam int CLK_HZ        = 10_000_000;
    localparam int SECOND_CYCLES = CLK_HZ;
    localparam logic [TIME_W-1:0] UTC_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  COUNT_RESET = 5'h00;

    typedef enum logic [1:0] {
        LDKS_OP_LOAD,
        LDKS_OP_PURGE,
        LDKS_OP_QUERY,
        LDKS_OP_NONE
    } ldks_op_t;

    typedef enum {
        LDKS_ST_IDLE,
        LDKS_ST_SCAN,
        LDKS_ST_LIST
    } ldks_state_t;
endpackage

// ==== core/ldks_top.sv ====
// link decryptor key store: session guard, key table, expiry, tamper log
`timescale 1ns/10ps
module ldks_top
    import ldks_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SECOND_CYCLES
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    // session requests
    input  wire logic                sess_open_in,
    input  wire logic                sess_close_in,
    input  wire logic [REQ_W-1:0]    sess_req_id_in,
    output logic                     sess_ack_out,
    output logic                     sess_nak_out,
    output logic                     sess_active_out,
    output logic      [REQ_W-1:0]    sess_owner_out,
    // commands
    input  wire logic                cmd_valid_in,
    input  wire logic [1:0]          cmd_op_in,
    input  wire logic [REQ_W-1:0]    cmd_req_id_in,
    input  wire logic [ID_W-1:0]     cmd_key_id_in,
    input  wire logic [KEY_W-1:0]    cmd_key_in,
    input  wire logic [PARAM_W-1:0]  cmd_param_in,
    input  wire logic [TIME_W-1:0]   cmd_valid_secs_in,
    output logic                     cmd_ready_out,
    output logic                     cmd_done_out,
    output logic                     cmd_err_out,
    output logic      [CNT_W-1:0]    key_count_out,
    output logic                     list_valid_out,
    output logic      [ID_W-1:0]     list_key_id_out,
    output logic      [KEY_W-1:0]    list_key_out,
    output logic      [PARAM_W-1:0]  list_param_out,
    // battery clock and tamper
    input  wire logic                utc_tick_in,
    input  wire logic                door_open_in,
    output logic      [TIME_W-1:0]   utc_time_out,
    output logic                     log_valid_out,
    output logic      [TIME_W-1:0]   log_stamp_out
);
    localparam int DATA_W = KEY_W + PARAM_W + ID_W;

    initial begin
        if (SEC_CYCLES < 1) begin
            $error("SEC_CYCLES must be at least one");
        end
    end

    function automatic logic [CNT_W-1:0] pop_count(input logic [SLOTS-1:0] v);
        logic [CNT_W-1:0] c;
        c = '0;
        for (int i = 0; i < SLOTS; i++) begin
            c = c + CNT_W'(v[i]);
        end
        return c;
    endfunction

    // synchronisers for pin inputs
    logic [1:0] tick_sync;
    logic [1:0] door_sync;
    logic       tick_last;
    logic       door_last;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_sync <= 2'h0;
            door_sync <= 2'h0;
            tick_last <= 1'b0;
            door_last <= 1'b0;
        end else begin
            tick_sync <= {tick_sync[0], utc_tick_in};
            door_sync <= {door_sync[0], door_open_in};
            tick_last <= tick_sync[1];
            door_last <= door_sync[1];
        end
    end

    // utc seconds: counted from battery tick rises only; the local divider runs but does not feed utc
    logic [TIME_W-1:0] utc;
    logic [31:0]       div;
    logic              sec_pulse;
    logic              tick_rise;
    logic              door_rise;

    assign tick_rise = tick_sync[1] & ~tick_last;
    assign door_rise = door_sync[1] & ~door_last;
    assign sec_pulse = tick_rise;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div <= 32'h0;
        end else if (div == 32'(SEC_CYCLES - 1)) begin
            div <= 32'h0;
        end else begin
            div <= div + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            utc <= UTC_RESET;
        end else if (sec_pulse) begin
            utc <= utc + 32'h1;
        end
    end

    // a door latched while unpowered is held at the pin by the battery side
    logic door_seen;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            door_seen     <= 1'b0;
            log_valid_out <= 1'b0;
            log_stamp_out <= UTC_RESET;
        end else begin
            log_valid_out <= 1'b0;
            if (door_sync[1] && !door_seen) begin
                door_seen     <= 1'b1;
                log_valid_out <= 1'b1;
                log_stamp_out <= utc;
            end else if (!door_sync[1]) begin
                door_seen <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            utc_time_out <= UTC_RESET;
        end else begin
            utc_time_out <= utc;
        end
    end

    // session guard
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sess_active_out <= 1'b0;
            sess_owner_out  <= '0;
            sess_ack_out    <= 1'b0;
            sess_nak_out    <= 1'b0;
        end else begin
            sess_ack_out <= 1'b0;
            sess_nak_out <= 1'b0;
            if (sess_close_in && sess_active_out && sess_req_id_in == sess_owner_out) begin
                sess_active_out <= 1'b0;
            end else if (sess_open_in) begin
                if (!sess_active_out) begin
                    sess_active_out <= 1'b1;
                    sess_owner_out  <= sess_req_id_in;
                    sess_ack_out    <= 1'b1;
                end else if (sess_req_id_in == sess_owner_out) begin
                    sess_ack_out <= 1'b1;
                end else begin
                    sess_nak_out <= 1'b1;
                end
            end
        end
    end

    // key table bookkeeping
    logic [SLOTS-1:0]  used;
    logic [ID_W-1:0]   ids   [SLOTS];
    logic [TIME_W-1:0] left  [SLOTS];
    ldks_state_t       state;
    logic [SLOT_W-1:0] scan;
    logic              last_scan;
    logic              cmd_ok;
    logic              hit;
    logic [SLOT_W-1:0] hit_idx;
    logic              free;
    logic [SLOT_W-1:0] free_idx;
    logic              wr_en;
    logic [SLOT_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic [SLOT_W-1:0] list_idx;
    logic              list_pend;

    assign cmd_ok = cmd_valid_in && cmd_ready_out && sess_active_out &&
                    cmd_req_id_in == sess_owner_out;

    always_comb begin
        hit      = 1'b0;
        hit_idx  = '0;
        free     = 1'b0;
        free_idx = '0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (used[i] && ids[i] == cmd_key_id_in) begin
                hit     = 1'b1;
                hit_idx = SLOT_W'(i);
            end
            if (!used[i]) begin
                free     = 1'b1;
                free_idx = SLOT_W'(i);
            end
        end
    end

    assign wr_en = cmd_ok && ldks_op_t'(cmd_op_in) == LDKS_OP_LOAD && (hit || free);
    assign last_scan = (scan == SLOT_W'(SLOTS - 1));
    assign rd_addr = scan;

    ldks_mem u_mem (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (wr_en),
        .wr_addr_in  (hit ? hit_idx : free_idx),
        .wr_data_in  ({cmd_key_id_in, cmd_key_in, cmd_param_in}),
        .rd_addr_in  (rd_addr),
        .rd_data_out (rd_data)
    );

    // slot state: load, purge, per-second expiry
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            used <= '0;
            for (int i = 0; i < SLOTS; i++) begin
                ids[i]  <= '0;
                left[i] <= '0;
            end
        end else begin
            if (sec_pulse) begin
                for (int i = 0; i < SLOTS; i++) begin
                    if (used[i]) begin
                        left[i] <= left[i] - 32'h1;
                        if (left[i] <= 32'h1) begin
                            used[i] <= 1'b0;
                        end
                    end
                end
            end
            if (cmd_ok && ldks_op_t'(cmd_op_in) == LDKS_OP_PURGE) begin
                used <= '0;
            end else if (wr_en && cmd_valid_secs_in != 32'h0) begin
                used[hit ? hit_idx : free_idx] <= 1'b1;
                ids[hit ? hit_idx : free_idx]  <= cmd_key_id_in;
                left[hit ? hit_idx : free_idx] <= cmd_valid_secs_in;
            end
        end
    end

    // command sequencer: query walks every slot and lists the live ones
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state         <= LDKS_ST_IDLE;
            scan          <= '0;
            list_idx      <= '0;
            list_pend     <= 1'b0;
            cmd_ready_out <= 1'b0;
            cmd_done_out  <= 1'b0;
            cmd_err_out   <= 1'b0;
            key_count_out <= COUNT_RESET;
        end else begin
            cmd_done_out <= 1'b0;
            cmd_err_out  <= 1'b0;
            list_pend    <= 1'b0;
            case (state)
                LDKS_ST_IDLE: begin
                    cmd_ready_out <= 1'b1;
                    if (cmd_valid_in && cmd_ready_out && !cmd_ok) begin
                        cmd_err_out <= 1'b1;
                    end else if (cmd_ok) begin
                        case (ldks_op_t'(cmd_op_in))
                            LDKS_OP_LOAD: begin
                                cmd_done_out <= hit || free;
                                cmd_err_out  <= !(hit || free);
                            end
                            LDKS_OP_PURGE: begin
                                cmd_done_out <= 1'b1;
                            end
                            LDKS_OP_QUERY: begin
                                cmd_ready_out <= 1'b0;
                                key_count_out <= pop_count(used);
                                scan          <= '0;
                                state         <= LDKS_ST_SCAN;
                            end
                            default: begin
                                cmd_err_out <= 1'b1;
                            end
                        endcase
                    end
                end
                LDKS_ST_SCAN: begin
                    // one cycle of memory read latency per slot
                    list_pend <= used[scan];
                    list_idx  <= scan;
                    state     <= LDKS_ST_LIST;
                end
                LDKS_ST_LIST: begin
                    if (last_scan) begin
                        cmd_done_out <= 1'b1;
                        state        <= LDKS_ST_IDLE;
                    end else begin
                        scan  <= scan + SLOT_W'(1);
                        state <= LDKS_ST_SCAN;
                    end
                end
                default: begin
                    state <= LDKS_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            list_valid_out  <= 1'b0;
            list_key_id_out <= '0;
            list_key_out    <= '0;
            list_param_out  <= '0;
        end else begin
            list_valid_out <= list_pend;
            if (list_pend) begin
                {list_key_id_out, list_key_out, list_param_out} <= rd_data;
            end
        end
    end
endmodule

// ==== verification/ldks_monitor.sv ====
// assertion checker on the key store top ports
`timescale 1ns/10ps
module ldks_monitor
    import ldks_pkg::*;
(
    input wire logic              clk_sys_in,
    input wire logic              rst_n_in,
    input wire logic              sess_open_in,
    input wire logic              sess_close_in,
    input wire logic [REQ_W-1:0]  sess_req_id_in,
    input wire logic              sess_ack_out,
    input wire logic              sess_nak_out,
    input wire logic              sess_active_out,
    input wire logic [REQ_W-1:0]  sess_owner_out,
    input wire logic              cmd_valid_in,
    input wire logic [1:0]        cmd_op_in,
    input wire logic [REQ_W-1:0]  cmd_req_id_in,
    input wire logic              cmd_ready_out,
    input wire logic              cmd_done_out,
    input wire logic              cmd_err_out,
    input wire logic [CNT_W-1:0]  key_count_out,
    input wire logic              list_valid_out,
    input wire logic [TIME_W-1:0] utc_time_out,
    input wire logic              log_valid_out,
    input wire logic [TIME_W-1:0] log_stamp_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    logic take;
    logic own;
    assign take = cmd_valid_in && cmd_ready_out;
    assign own  = sess_active_out && (cmd_req_id_in == sess_owner_out);

    sess_single_a: assert property (!(sess_ack_out && sess_nak_out))
        else $error("ack and nak together");
    sess_accept_a: assert property (
        sess_open_in && !sess_close_in && !sess_active_out |=>
        sess_ack_out && sess_active_out && sess_owner_out == $past(sess_req_id_in))
        else $error("free session not granted");
    sess_refuse_a: assert property (
        sess_open_in && !sess_close_in && sess_active_out &&
        sess_req_id_in != sess_owner_out |=> sess_nak_out && !sess_ack_out)
        else $error("second requester not refused");
    owner_hold_a: assert property (
        sess_active_out && !sess_close_in |=> sess_active_out && $stable(sess_owner_out))
        else $error("owner changed while open");
    load_answer_a: assert property (
        take && cmd_op_in == LDKS_OP_LOAD && own |=> cmd_done_out ^ cmd_err_out)
        else $error("load not answered");
    purge_done_a: assert property (
        take && cmd_op_in == LDKS_OP_PURGE && own |=> cmd_done_out && !cmd_err_out)
        else $error("purge not done");
    query_time_a: assert property (
        take && cmd_op_in == LDKS_OP_QUERY && own |-> ##1 !cmd_ready_out ##32 cmd_done_out)
        else $error("query end misplaced");
    count_cap_a: assert property (key_count_out <= 5'h10)
        else $error("count above table size");
    list_query_a: assert property (list_valid_out |-> !cmd_ready_out)
        else $error("list entry outside query");
    utc_step_a: assert property (
        utc_time_out != $past(utc_time_out) |-> utc_time_out == $past(utc_time_out) + 32'h1)
        else $error("utc jumped");
    log_stamp_a: assert property (
        log_valid_out && $stable(utc_time_out) |-> log_stamp_out == utc_time_out)
        else $error("log stamp wrong");
endmodule

bind ldks_top ldks_monitor ldks_monitor_i (.clk_sys_in, .rst_n_in, .sess_open_in,
    .sess_close_in, .sess_req_id_in, .sess_ack_out, .sess_nak_out, .sess_active_out,
    .sess_owner_out, .cmd_valid_in, .cmd_op_in, .cmd_req_id_in, .cmd_ready_out,
    .cmd_done_out, .cmd_err_out, .key_count_out, .list_valid_out, .utc_time_out,
    .log_valid_out, .log_stamp_out);

// ==== verification/ldks_sm_model.sv ====
// security manager model issuing session and key commands
`timescale 1ns/10ps
module ldks_sm_model
    import ldks_pkg::*;
(
    input  wire logic               clk_sys_in,
    input  wire logic               sess_ack_in,
    input  wire logic               sess_nak_in,
    input  wire logic               cmd_ready_in,
    input  wire logic               cmd_done_in,
    input  wire logic               cmd_err_in,
    input  wire logic               list_valid_in,
    output logic                    sess_open_out,
    output logic                    sess_close_out,
    output logic      [REQ_W-1:0]   sess_req_id_out,
    output logic                    cmd_valid_out,
    output logic      [1:0]         cmd_op_out,
    output logic      [REQ_W-1:0]   cmd_req_id_out,
    output logic      [ID_W-1:0]    cmd_key_id_out,
    output logic      [KEY_W-1:0]   cmd_key_out,
    output logic      [PARAM_W-1:0] cmd_param_out,
    output logic      [TIME_W-1:0]  cmd_valid_secs_out
);
    initial begin
        sess_open_out = 1'b0;
        sess_close_out = 1'b0;
        sess_req_id_out = '0;
        cmd_valid_out = 1'b0;
        cmd_op_out = 2'h3;
        cmd_req_id_out = '0;
        cmd_key_id_out = '0;
        cmd_key_out = '0;
        cmd_param_out = '0;
        cmd_valid_secs_out = '0;
    end
    task automatic open_sess(input logic [REQ_W-1:0] id, output logic ack, output logic nak);
        int n;
        sess_req_id_out = id;
        sess_open_out = 1'b1;
        @(negedge clk_sys_in);
        sess_open_out = 1'b0;
        sess_req_id_out = ~id;
        ack = 1'b0;
        nak = 1'b0;
        for (n = 0; n < 4; n++) begin
            ack = ack | sess_ack_in;
            nak = nak | sess_nak_in;
            @(negedge clk_sys_in);
        end
        // a refused requester keeps no command rights
        if (ack) cmd_req_id_out = id;
    endtask
    task automatic close_sess(input logic [REQ_W-1:0] id);
        sess_req_id_out = id;
        sess_close_out = 1'b1;
        @(negedge clk_sys_in);
        sess_close_out = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic issue(input logic [1:0] op, input logic [ID_W-1:0] kid,
                         input logic [TIME_W-1:0] secs,
                         output logic done, output logic err, output int lists);
        int n;
        for (n = 0; n < 40 && cmd_ready_in !== 1'b1; n++) @(negedge clk_sys_in);
        cmd_op_out = op;
        cmd_key_id_out = kid;
        cmd_key_out = {(KEY_W/ID_W){kid}};
        cmd_param_out = ~kid;
        cmd_valid_secs_out = secs;
        cmd_valid_out = 1'b1;
        @(negedge clk_sys_in);
        cmd_valid_out = 1'b0;
        cmd_key_id_out = ~kid;
        cmd_key_out = ~cmd_key_out;
        done = 1'b0;
        err = 1'b0;
        lists = 0;
        // done and err stand one cycle: look before the next edge, then let one pass
        for (n = 0; n < 40 && !done && !err; n++) begin
            done = (cmd_done_in === 1'b1);
            err = (cmd_err_in === 1'b1);
            lists += int'(list_valid_in === 1'b1);
            @(negedge clk_sys_in);
        end
    endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench of the key store
`timescale 1ns/10ps
module testbench
    import ldks_pkg::*;
;
    logic clk_sys_in, rst_n_in, utc_tick_in, door_open_in, d, e, a, n;
    logic sess_open_in, sess_close_in, sess_ack_out, sess_nak_out, sess_active_out;
    logic cmd_valid_in, cmd_ready_out, cmd_done_out, cmd_err_out, list_valid_out;
    logic log_valid_out;
    logic [REQ_W-1:0]   sess_req_id_in, sess_owner_out, cmd_req_id_in;
    logic [1:0]         cmd_op_in;
    logic [ID_W-1:0]    cmd_key_id_in, list_key_id_out;
    logic [KEY_W-1:0]   cmd_key_in, list_key_out;
    logic [PARAM_W-1:0] cmd_param_in, list_param_out;
    logic [TIME_W-1:0]  cmd_valid_secs_in, utc_time_out, log_stamp_out;
    logic [CNT_W-1:0]   key_count_out;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    int                 lists;
    int                 nticks = 0;

    ldks_top #(.SEC_CYCLES(4)) ldks_top_i (.clk_sys_in, .rst_n_in, .sess_open_in,
        .sess_close_in, .sess_req_id_in, .sess_ack_out, .sess_nak_out, .sess_active_out,
        .sess_owner_out, .cmd_valid_in, .cmd_op_in, .cmd_req_id_in, .cmd_key_id_in,
        .cmd_key_in, .cmd_param_in, .cmd_valid_secs_in, .cmd_ready_out, .cmd_done_out,
        .cmd_err_out, .key_count_out, .list_valid_out, .list_key_id_out,
        .list_key_out, .list_param_out, .utc_tick_in, .door_open_in,
        .utc_time_out, .log_valid_out, .log_stamp_out);
    ldks_sm_model ldks_sm_model_i (.clk_sys_in, .sess_ack_in(sess_ack_out),
        .sess_nak_in(sess_nak_out), .cmd_ready_in(cmd_ready_out),
        .cmd_done_in(cmd_done_out), .cmd_err_in(cmd_err_out),
        .list_valid_in(list_valid_out), .sess_open_out(sess_open_in),
        .sess_close_out(sess_close_in), .sess_req_id_out(sess_req_id_in),
        .cmd_valid_out(cmd_valid_in), .cmd_op_out(cmd_op_in),
        .cmd_req_id_out(cmd_req_id_in), .cmd_key_id_out(cmd_key_id_in),
        .cmd_key_out(cmd_key_in), .cmd_param_out(cmd_param_in),
        .cmd_valid_secs_out(cmd_valid_secs_in));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic tick(input int cnt);
        repeat (cnt) begin
            utc_tick_in = 1'b1;
            repeat (4) @(negedge clk_sys_in);
            utc_tick_in = 1'b0;
            repeat (4) @(negedge clk_sys_in);
            nticks++;
        end
    endtask
    task automatic see_log(input string nm);
        logic got;
        got = 1'b0;
        for (int i = 0; i < 12 && !got; i++) begin
            @(negedge clk_sys_in);
            got = log_valid_out === 1'b1;
        end
        chk(nm, 1, got);
        chk({nm, " stamp"}, UTC_RESET + nticks, log_stamp_out);
        door_open_in = 1'b0;
    endtask
    task automatic query(input int ex, input string nm);
        ldks_sm_model_i.issue(LDKS_OP_QUERY, '0, '0, d, e, lists);
        chk({nm, " done"}, 1, d);
        chk({nm, " count"}, ex, key_count_out);
        chk({nm, " list"}, ex, lists);
    endtask
    task automatic load(input int id, input int secs, input logic ex_err);
        ldks_sm_model_i.issue(LDKS_OP_LOAD, id, secs, d, e, lists);
        chk("load err", ex_err, e);
        chk("load done", !ex_err, d);
    endtask
    task automatic t_session();
        ldks_sm_model_i.open_sess(8'h01, a, n);
        chk("free open ack", 1, a);
        chk("owner", 8'h01, sess_owner_out);
        ldks_sm_model_i.open_sess(8'h02, a, n);
        chk("busy open nak", 1, n);
        chk("owner kept", 8'h01, sess_owner_out);
        ldks_sm_model_i.close_sess(8'h02);
        chk("foreign close", 1, sess_active_out);
        ldks_sm_model_i.close_sess(8'h01);
        chk("owner close", 0, sess_active_out);
        ldks_sm_model_i.issue(LDKS_OP_PURGE, '0, '0, d, e, lists);
        chk("closed cmd err", 1, e);
        ldks_sm_model_i.open_sess(8'h02, a, n);
        chk("reopen ack", 1, a);
        chk("new owner", 8'h02, sess_owner_out);
    endtask
    task automatic t_purge();
        ldks_sm_model_i.issue(LDKS_OP_PURGE, '0, '0, d, e, lists);
        chk("purge done", 1, d);
        query(0, "after purge");
        ldks_sm_model_i.issue(2'h3, '0, '0, d, e, lists);
        chk("unknown op err", 1, e);
    endtask
    task automatic t_capacity();
        for (int i = 1; i <= 16; i++) load(i, 1000, 1'b0);
        load(16, 1000, 1'b0);
        load(17, 1000, 1'b1);
        query(16, "full table");
    endtask
    task automatic t_expiry();
        load(4, 60, 1'b0);
        query(1, "fresh key");
        chk("list key id", 32'h0000_0004, list_key_id_out);
        chk("list param", ~32'h0000_0004, list_param_out);
        chk("list key", 1, list_key_out === {4{32'h0000_0004}});
        tick(59);
        query(1, "before expiry");
        tick(1);
        query(0, "after minute");
    endtask
    task automatic t_door();
        tick(3);
        chk("utc running", UTC_RESET + nticks, utc_time_out);
        door_open_in = 1'b1;
        see_log("door powered");
    endtask
    task automatic wrap_up();
        $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        rst_n_in = 1'b0;
        utc_tick_in = 1'b0;
        // door latched open by the battery side while unpowered
        door_open_in = 1'b1;
        repeat (5) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        see_log("door unpowered");
        t_session();
        t_purge();
        t_capacity();
        t_purge();
        t_expiry();
        t_door();
        wrap_up();
    end
    initial begin
        repeat (8000) @(posedge clk_sys_in);
        error_cnt++;
        wrap_up();
    end
endmodule
